// [dv/eslmc_host.sv]
// Purpose: Host bus model facing the serial mux control registers
// Assumes: Strobes change on the falling edge and last one cycle
// Notes: Released data lines show inverted values after a write, address lines after a read
module eslmc_host (
    input wire logic clk,
    output eslmc_pkg::eslmc_bus_s bus,
    input wire logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import eslmc_pkg::*;
    initial begin
        bus = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge clk);
        bus.addr = a;
        bus.be = be;
        bus.wdata = d;
        bus.wr = 1'b1;
        @(negedge clk);
        bus.wr = 1'b0;
        bus.wdata = ~d;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(negedge clk);
        bus.addr = a;
        bus.rd = 1'b1;
        @(negedge clk);
        d = rdata;
        bus.rd = 1'b0;
        bus.addr = ~a;
        if (a == ADDR_RECEIVE_BUFFER_WORD) begin
            repeat (250) @(negedge clk);
        end
    endtask : rd
endmodule : eslmc_host

// [dv/eslmc_top_tb_top.sv]
// Purpose: Self-checking bench of the serial mux control block
// Assumes: Maintenance loopback carries characters back to the silo
// Notes: Shortened clock parameter makes 9600 baud 100 cycles a bit
module eslmc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import eslmc_pkg::*;
    logic clk;
    logic reset;
    eslmc_bus_s bus;
    logic [15:0] rdata;
    logic [7:0] rx_line;
    logic [7:0] tx_line;
    eslmc_modem_s modem;
    logic [7:0] term_ready;
    logic rx_intr;
    logic tx_intr;
    int failures;
    int n_tests;
    logic [15:0] d;
    logic [15:0] v;
    logic [7:0] brk;
    logic [7:0] ch;
    logic [2:0] line;
    logic [1:0] len;
    logic par;
    logic odd;
    logic stp;
    int unsigned seed;
    ////////////////////////////////////////////////////////////////////////////////
    eslmc_top #(.CLK_HZ(960000), .MODEM_PRESENT(1'b1)) i_eslmc_top (
        .clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .rx_line(rx_line),
        .tx_line(tx_line), .modem(modem), .term_ready(term_ready),
        .rx_intr(rx_intr), .tx_intr(tx_intr)
    );
    eslmc_host i_eslmc_host (.clk(clk), .bus(bus), .rdata(rdata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_irq(input bit rx);
        int n;
        n = 0;
        while (((rx ? rx_intr : tx_intr) !== 1'b1) && n < 20000) begin
            @(negedge clk);
            n++;
        end
        check(rx ? "rx_intr" : "tx_intr", 16'h0001, {15'h0, rx ? rx_intr : tx_intr});
    endtask : wait_irq
    task automatic send_rx(input logic [10:0] fr);
        for (int b = 0; b < 11; b++) begin
            @(negedge clk);
            rx_line = {8{fr[b]}};
            repeat (99) @(negedge clk);
        end
    endtask : send_rx
    function automatic logic [15:0] exp_receive_buffer_word(input logic [2:0] ln, input logic [1:0] ln_code,
        input logic [7:0] c);
        logic [7:0] m;
        m = 8'hff >> (2'h3 - ln_code);
        return {1'b1, 4'h0, ln, c & m};
    endfunction : exp_receive_buffer_word
    task automatic conclude();
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        n_tests = 0;
        seed = $urandom(55028);
        reset = 1'b1;
        modem = '0;
        rx_line = 8'hff;
        repeat (6) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        check("tx_line", 16'h00ff, {8'h0, tx_line});
        check("term_ready", 16'h0, {8'h0, term_ready});
        i_eslmc_host.rd(ADDR_TCR, d);
        check("line enables", 16'h0, d);
        modem = eslmc_modem_s'(16'($urandom));
        i_eslmc_host.rd(ADDR_MSR, d);
        check("modem status", modem, d);
        v = 16'($urandom);
        i_eslmc_host.wr(ADDR_TCR, 2'h3, v);
        i_eslmc_host.rd(ADDR_TCR, d);
        check("line enables", v, d);
        check("term_ready", {8'h0, v[15:8]}, {8'h0, term_ready});
        brk = 8'($urandom) | 8'h01;
        i_eslmc_host.wr(ADDR_MSR, 2'h2, {brk, 8'h0});
        repeat (2) @(negedge clk);
        check("break", {8'h0, ~brk}, {8'h0, tx_line});
        i_eslmc_host.wr(ADDR_CSR, 2'h1, 16'h0008);
        repeat (2) @(negedge clk);
        check("maint break", 16'h00ff, {8'h0, tx_line});
        i_eslmc_host.wr(ADDR_CSR, 2'h1, 16'h0010);
        repeat (3) @(negedge clk);
        check("clear break", 16'h00ff, {8'h0, tx_line});
        i_eslmc_host.rd(ADDR_TCR, d);
        check("soft clear", {v[15:8], 8'h0}, d);
        i_eslmc_host.rd(ADDR_MSR, d);
        check("modem status", modem, d);
        i_eslmc_host.rd(ADDR_RECEIVE_BUFFER_WORD, d);
        check("empty valid", 16'h0, {15'h0, d[RB_VALID]});
        check("rx_intr", 16'h0, {15'h0, rx_intr});
        for (int i = 0; i < 4; i++) begin
            line = (i == 0) ? 3'h7 : 3'($urandom);
            len = (i == 0) ? 2'h0 : 2'($urandom);
            ch = 8'($urandom);
            par = 1'($urandom);
            odd = 1'($urandom);
            stp = 1'($urandom);
            i_eslmc_host.wr(ADDR_RECEIVE_BUFFER_WORD, 2'h3, {4'h1, 4'he, odd, par, stp, len, line});
            i_eslmc_host.wr(ADDR_TCR, 2'h1, {8'h0, 8'h01 << line});
            i_eslmc_host.wr(ADDR_CSR, 2'h3, 16'h4068);
            wait_irq(1'b0);
            i_eslmc_host.rd(ADDR_CSR, d);
            check("ready line", {12'h0, 1'b1, line}, {12'h0, d[15], d[10:8]});
            i_eslmc_host.wr(ADDR_MSR, 2'h1, {8'h0, ch});
            wait_irq(1'b1);
            check("tx_intr", 16'h0, {15'h0, tx_intr});
            i_eslmc_host.rd(ADDR_RECEIVE_BUFFER_WORD, d);
            check("receive_buffer_word", exp_receive_buffer_word(line, len, ch), d);
            i_eslmc_host.rd(ADDR_RECEIVE_BUFFER_WORD, d);
            check("drained", 16'h0, {15'h0, d[RB_VALID]});
        end
        i_eslmc_host.wr(ADDR_CSR, 2'h3, 16'h1060);
        odd = 1'($urandom);
        for (int i = 0; i < NLINES; i++) begin
            i_eslmc_host.wr(ADDR_RECEIVE_BUFFER_WORD, 2'h3, {4'h1, 4'he, odd, 1'b1, 1'b0, 2'h3, 3'(i)});
        end
        ch = 8'($urandom);
        send_rx({1'b1, ^ch ^ odd ^ 1'b1, ch, 1'b0});
        check("alarm early", 16'h0, {15'h0, rx_intr});
        v[7:0] = 8'($urandom);
        send_rx({1'b1, ^v[7:0] ^ odd ^ 1'b1, v[7:0], 1'b0});
        wait_irq(1'b1);
        for (int k = 0; k < 17; k++) begin
            i_eslmc_host.rd(ADDR_RECEIVE_BUFFER_WORD, d);
            check("silo word", (k < 16) ? {4'h9, 4'h0, (k < 8) ? ch : v[7:0]} : 16'h0,
                d & ((k < 16) ? 16'hf8ff : 16'h8000));
        end
        conclude();
    end
endmodule : eslmc_top_tb_top

// [logic/eslmc_pkg.sv]
// Purpose: Shared constants and types of the eight-line serial mux control block
// Assumes: One 250 MHz clock, byte addresses on the register port
// Notes: Baud table is held in tenths of a baud
package eslmc_pkg;
    localparam int NLINES = 8;
    localparam longint CLK_HZ_DEFAULT = 250_000_000;
    localparam logic [2:0] ADDR_CSR = 3'h0;
    localparam logic [2:0] ADDR_RECEIVE_BUFFER_WORD = 3'h2;
    localparam logic [2:0] ADDR_TCR = 3'h4;
    localparam logic [2:0] ADDR_MSR = 3'h6;
    localparam int CSR_MAINT = 3;
    localparam int CSR_CLR = 4;
    localparam int CSR_MSE = 5;
    localparam int CSR_RIE = 6;
    localparam int CSR_RECEIVE_DONE_FLAG = 7;
    localparam int CSR_SAE = 12;
    localparam int CSR_SA = 13;
    localparam int CSR_TIE = 14;
    localparam int CSR_TRANSMITTER_READY_FLAG = 15;
    localparam int LPR_LEN = 3;
    localparam int LPR_STOP = 5;
    localparam int LPR_PAR = 6;
    localparam int LPR_ODD = 7;
    localparam int LPR_SPD = 8;
    localparam int LPR_RXON = 12;
    localparam int RB_VALID = 15;
    localparam int SILO_DEPTH = 64;
    localparam logic [4:0] ALARM_COUNT = 5'h10;
    localparam logic [3:0] SPEED_UNUSED = 4'hf;
    localparam logic [3:0] LEN_BASE = 4'h5;
    localparam logic [3:0] RX_SH_BITS = 4'ha;
    localparam logic [4:0] STOP_1 = 5'h2;
    localparam logic [4:0] STOP_15 = 5'h3;
    localparam logic [4:0] STOP_2 = 5'h4;
    localparam longint HALF_NUM = 5;
    localparam longint BAUD_X10 [15] = '{500, 750, 1100, 1345, 1500, 3000, 6000, 12000,
        18000, 20000, 24000, 36000, 48000, 72000, 96000};
    typedef struct packed {
        logic [2:0] addr;
        logic rd;
        logic wr;
        logic [1:0] be;
        logic [15:0] wdata;
    } eslmc_bus_s;
    typedef struct packed {
        logic [7:0] carrier;
        logic [7:0] ring;
    } eslmc_modem_s;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} eslmc_rx_e;
endpackage : eslmc_pkg

// [logic/eslmc_top.sv]
// Purpose: Line control, silo and host registers of an eight-line serial mux
// Assumes: Inputs synchronous to clk; reset is bus initialize
// Notes: Function
// Function
// - Modem option: upper LINE_ENABLE_AND_TERMINAL_READY byte holds terminal-ready bits, kept by soft clear
// - Without modem option upper LINE_ENABLE_AND_TERMINAL_READY byte reads zero, writes ignored
// - Lower LINE_ENABLE_AND_TERMINAL_READY byte holds line enables, cleared by soft clear and init
// - Modem status shows ring low byte, carrier high byte, never cleared
// - Without modem option modem status reads all zero
// - Transmit word: low byte character, high byte per-line break to zeros
// - Unused upper character bits forced to zero for short lengths
// - Break bits ignored while maintenance mode set
// - Character and break contents cleared by soft clear and init
// - Four-bit speed code picks one shared rate per line; 1111 unused
// - Receiver-on bit turns selected line receiver clock on or off
// - Length code gives 5 to 8 bits; unused received bits zero
// - Stop bit: one unit, or two, or 1.5 with 5-bit length
// - Parity enable governs generate and check; kind ignored otherwise
// - Parity kept out of character fields; bad parity sets error flag
// - Receive-done set while silo holds a character; no irq when disabled
// - Receiver irq with done set when alarm disabled
// - Alarm after 16 entries since last buffer access; access clears it
// - Transmitter irq while ready flag set and enabled and receiver irq not asserted
// - Each buffer read pops the silo; valid zero means empty
// - Parity kind bit: zero even, one odd
// - Line number field picks the line for a parameter write
// - Top buffer bit is valid flag, set only for real characters
module eslmc_top #(
    parameter longint CLK_HZ = eslmc_pkg::CLK_HZ_DEFAULT,
    parameter bit MODEM_PRESENT = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire eslmc_pkg::eslmc_bus_s bus,
    output logic [15:0] rdata,
    input wire logic [7:0] rx_line,
    output logic [7:0] tx_line,
    input wire eslmc_pkg::eslmc_modem_s modem,
    output logic [7:0] term_ready,
    output logic rx_intr,
    output logic tx_intr
);
    import eslmc_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    function automatic logic [23:0] half_div(input logic [3:0] s);
        half_div = '0;
        if (s != SPEED_UNUSED) begin
            half_div = 24'((CLK_HZ * HALF_NUM) / BAUD_X10[s]);
        end
    endfunction : half_div

    function automatic logic [7:0] char_mask(input logic [1:0] len);
        char_mask = 8'hff >> (2'h3 - len);
    endfunction : char_mask

    ////////////////////////////////////////////////////////////////////////////
    // Host registers
    logic maint, mse, receiver_interrupt_enable, silo_alarm_enable, transmitter_interrupt_enable, transmitter_ready_flag, clr_now;
    logic [2:0] tline;
    logic [7:0] line_en, dtr, brk, tx_hold;
    logic [3:0] lp_spd [NLINES];
    logic [1:0] lp_len [NLINES];
    logic [NLINES-1:0] lp_stop, lp_par, lp_odd, lp_rxon, tx_full, rx_hv;
    logic next_maint, next_mse, next_rie, next_sae, next_tie, next_transmitter_ready_flag, next_clr_now;
    logic [2:0] next_tline;
    logic [7:0] next_line_en, next_dtr, next_brk, next_tx_hold;
    logic [15:0] next_rdata;
    logic [3:0] next_lp_spd [NLINES];
    logic [1:0] next_lp_len [NLINES];
    logic [NLINES-1:0] next_lp_stop, next_lp_par, next_lp_odd, next_lp_rxon;
    logic wr_csr, wr_lpr, wr_tcr, wr_tdr, rd_receive_buffer_word, transmit_character_byte_wr, receive_done_flag, sa, empty;
    logic [14:0] silo_head;

    assign wr_csr = bus.wr && bus.addr == ADDR_CSR;
    assign wr_lpr = bus.wr && bus.addr == ADDR_RECEIVE_BUFFER_WORD;
    assign wr_tcr = bus.wr && bus.addr == ADDR_TCR;
    assign wr_tdr = bus.wr && bus.addr == ADDR_MSR;
    assign rd_receive_buffer_word = bus.rd && bus.addr == ADDR_RECEIVE_BUFFER_WORD;
    assign transmit_character_byte_wr = wr_tdr && bus.be[0] && transmitter_ready_flag;
    assign receive_done_flag = !empty && mse;
    assign rx_intr = receiver_interrupt_enable && (silo_alarm_enable ? sa : receive_done_flag);
    assign tx_intr = transmitter_interrupt_enable && transmitter_ready_flag && !rx_intr;

    always_comb begin
        next_maint = maint;
        next_mse = mse;
        next_rie = receiver_interrupt_enable;
        next_sae = silo_alarm_enable;
        next_tie = transmitter_interrupt_enable;
        next_clr_now = 1'b0;
        next_transmitter_ready_flag = transmitter_ready_flag;
        next_tline = tline;
        next_line_en = line_en;
        next_dtr = dtr;
        next_brk = brk;
        next_tx_hold = tx_hold;
        next_lp_spd = lp_spd;
        next_lp_len = lp_len;
        next_lp_stop = lp_stop;
        next_lp_par = lp_par;
        next_lp_odd = lp_odd;
        next_lp_rxon = lp_rxon;
        next_rdata = '0;
        if (wr_csr && bus.be[0]) begin
            next_maint = bus.wdata[CSR_MAINT];
            next_clr_now = bus.wdata[CSR_CLR];
            next_mse = bus.wdata[CSR_MSE];
            next_rie = bus.wdata[CSR_RIE];
        end
        if (wr_csr && bus.be[1]) begin
            next_sae = bus.wdata[CSR_SAE];
            next_tie = bus.wdata[CSR_TIE];
        end
        if (wr_lpr) begin
            next_lp_len[bus.wdata[2:0]] = bus.wdata[LPR_LEN +: 2];
            next_lp_stop[bus.wdata[2:0]] = bus.wdata[LPR_STOP];
            next_lp_par[bus.wdata[2:0]] = bus.wdata[LPR_PAR];
            next_lp_odd[bus.wdata[2:0]] = bus.wdata[LPR_ODD];
            next_lp_spd[bus.wdata[2:0]] = bus.wdata[LPR_SPD +: 4];
            next_lp_rxon[bus.wdata[2:0]] = bus.wdata[LPR_RXON];
        end
        if (wr_tcr && bus.be[0]) begin
            next_line_en = bus.wdata[7:0];
        end
        if (wr_tcr && bus.be[1] && MODEM_PRESENT) begin
            next_dtr = bus.wdata[15:8];
        end
        if (wr_tdr && bus.be[1]) begin
            next_brk = bus.wdata[15:8];
        end
        if (transmit_character_byte_wr) begin
            next_tx_hold = bus.wdata[7:0];
            next_transmitter_ready_flag = 1'b0;
        end else if (transmitter_ready_flag && !line_en[tline]) begin
            next_transmitter_ready_flag = 1'b0;
        end else if (!transmitter_ready_flag && mse) begin
            for (int i = 0; i < NLINES; i++) begin
                if (line_en[i] && !tx_full[i]) begin
                    next_transmitter_ready_flag = 1'b1;
                    next_tline = 3'(i);
                end
            end
        end
        if (bus.rd) begin
            case (bus.addr)
                ADDR_CSR: next_rdata = {transmitter_ready_flag, transmitter_interrupt_enable, sa, silo_alarm_enable, 1'b0, tline, receive_done_flag, receiver_interrupt_enable, mse,
                    clr_now, maint, 3'h0};
                ADDR_RECEIVE_BUFFER_WORD: next_rdata = {receive_done_flag, receive_done_flag ? silo_head : 15'h0};
                ADDR_TCR: next_rdata = {MODEM_PRESENT ? dtr : 8'h0, line_en};
                ADDR_MSR: next_rdata = MODEM_PRESENT ? modem : 16'h0;
                default: next_rdata = '0;
            endcase
        end
        if (clr_now) begin
            next_maint = 1'b0;
            next_mse = 1'b0;
            next_rie = 1'b0;
            next_sae = 1'b0;
            next_tie = 1'b0;
            next_transmitter_ready_flag = 1'b0;
            next_line_en = '0;
            next_brk = '0;
            next_tx_hold = '0;
            next_lp_rxon = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            {maint, mse, receiver_interrupt_enable, silo_alarm_enable, transmitter_interrupt_enable, transmitter_ready_flag, clr_now} <= '0;
            tline <= '0;
            line_en <= '0;
            dtr <= '0;
            brk <= '0;
            tx_hold <= '0;
            rdata <= '0;
            lp_spd <= '{default: '0};
            lp_len <= '{default: '0};
            {lp_stop, lp_par, lp_odd, lp_rxon} <= '0;
        end else begin
            {maint, mse, receiver_interrupt_enable, silo_alarm_enable, transmitter_interrupt_enable, transmitter_ready_flag, clr_now} <= {next_maint, next_mse, next_rie,
                next_sae, next_tie, next_transmitter_ready_flag, next_clr_now};
            tline <= next_tline;
            line_en <= next_line_en;
            dtr <= next_dtr;
            brk <= next_brk;
            tx_hold <= next_tx_hold;
            rdata <= next_rdata;
            lp_spd <= next_lp_spd;
            lp_len <= next_lp_len;
            {lp_stop, lp_par, lp_odd, lp_rxon} <= {next_lp_stop, next_lp_par, next_lp_odd,
                next_lp_rxon};
        end
    end
    assign term_ready = dtr;

    ////////////////////////////////////////////////////////////////////////////
    // Silo
    logic [14:0] silo [SILO_DEPTH];
    logic [6:0] wp, rp, next_wp, next_rp;
    logic [4:0] alarm_cnt, next_alarm_cnt;
    logic push_en, full;
    logic [2:0] push_sel;
    logic [14:0] rx_hw [NLINES];

    assign empty = wp == rp;
    assign full = (wp - rp) == 7'(SILO_DEPTH);
    assign silo_head = silo[rp[5:0]];
    assign sa = alarm_cnt == ALARM_COUNT;

    always_comb begin
        push_sel = '0;
        for (int i = 0; i < NLINES; i++) begin
            if (rx_hv[i]) begin
                push_sel = 3'(i);
            end
        end
        push_en = |rx_hv && !full && mse;
        next_wp = push_en ? wp + 7'h1 : wp;
        next_rp = (rd_receive_buffer_word && !empty) ? rp + 7'h1 : rp;
        next_alarm_cnt = alarm_cnt;
        if (rd_receive_buffer_word) begin
            next_alarm_cnt = {4'h0, push_en};
        end else if (push_en && !sa) begin
            next_alarm_cnt = alarm_cnt + 5'h1;
        end
        if (clr_now || !mse) begin
            next_rp = wp;
            next_wp = wp;
            next_alarm_cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wp <= '0;
            rp <= '0;
            alarm_cnt <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            alarm_cnt <= next_alarm_cnt;
        end
        if (push_en) begin
            silo[wp[5:0]] <= rx_hw[push_sel];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line engines
    logic [23:0] tx_tmr [NLINES], rx_tmr [NLINES], next_tx_tmr [NLINES], next_rx_tmr [NLINES];
    logic [11:0] tx_sh [NLINES], next_tx_sh [NLINES];
    logic [4:0] tx_half [NLINES], next_tx_half [NLINES];
    logic [9:0] rx_sh [NLINES], next_rx_sh [NLINES];
    logic [3:0] rx_n [NLINES], next_rx_n [NLINES];
    logic [14:0] next_rx_hw [NLINES];
    eslmc_rx_e rx_st [NLINES], next_rx_st [NLINES];
    logic [NLINES-1:0] tx_ph, next_tx_ph, next_tx_full, next_rx_hv, next_tx_line;

    always_comb begin
        logic [11:0] fr;
        logic [9:0] v;
        logic [7:0] ch;
        logic [3:0] ln, nb;
        logic rxd;
        logic [23:0] hd;
        fr = '0;
        hd = '0;
        v = '0;
        ch = '0;
        ln = '0;
        nb = '0;
        rxd = 1'b1;
        next_tx_tmr = tx_tmr;
        next_rx_tmr = rx_tmr;
        next_tx_sh = tx_sh;
        next_tx_half = tx_half;
        next_tx_ph = tx_ph;
        next_tx_full = tx_full;
        next_rx_sh = rx_sh;
        next_rx_n = rx_n;
        next_rx_st = rx_st;
        next_rx_hv = rx_hv;
        next_rx_hw = rx_hw;
        for (int i = 0; i < NLINES; i++) begin
            ln = LEN_BASE + 4'(lp_len[i]);
            hd = half_div(lp_spd[i]);
            nb = ln + 4'(lp_par[i]);
            next_tx_tmr[i] = (tx_tmr[i] == '0) ? half_div(lp_spd[i]) : tx_tmr[i] - 24'h1;
            if (tx_tmr[i] == '0 && lp_spd[i] != SPEED_UNUSED) begin
                if (tx_half[i] != '0) begin
                    next_tx_half[i] = tx_half[i] - 5'h1;
                    next_tx_ph[i] = !tx_ph[i];
                    if (tx_ph[i]) begin
                        next_tx_sh[i] = {1'b1, tx_sh[i][11:1]};
                    end
                end else if (tx_full[i]) begin
                    ch = tx_hold & char_mask(lp_len[i]);
                    fr = (12'hfff << nb) | {4'h0, ch};
                    if (lp_par[i]) begin
                        fr = (fr & ~(12'h1 << ln)) | (12'(^ch ^ lp_odd[i]) << ln);
                    end
                    next_tx_sh[i] = {fr[10:0], 1'b0};
                    // Extra half unit lets the last stop unit run its full length
                    next_tx_half[i] = {nb, 1'b0} + 5'h1 + STOP_1 + (!lp_stop[i] ? 5'h0 :
                        (lp_len[i] == 2'h0 ? STOP_15 - STOP_1 : STOP_2 - STOP_1));
                    next_tx_ph[i] = 1'b0;
                    next_tx_full[i] = 1'b0;
                end
            end
            if (transmit_character_byte_wr && tline == 3'(i)) begin
                next_tx_full[i] = 1'b1;
            end
            if (push_en && push_sel == 3'(i)) begin
                next_rx_hv[i] = 1'b0;
            end
            rxd = maint ? tx_sh[i][0] : rx_line[i];
            case (rx_st[i])
                RX_IDLE: begin
                    if (!rxd) begin
                        next_rx_st[i] = RX_START;
                        next_rx_tmr[i] = half_div(lp_spd[i]);
                    end
                end
                RX_START: begin
                    next_rx_tmr[i] = rx_tmr[i] - 24'h1;
                    if (rx_tmr[i] == '0) begin
                        next_rx_st[i] = rxd ? RX_IDLE : RX_BITS;
                        next_rx_tmr[i] = {hd[22:0], 1'b0};
                        next_rx_n[i] = '0;
                    end
                end
                RX_BITS: begin
                    next_rx_tmr[i] = rx_tmr[i] - 24'h1;
                    if (rx_tmr[i] == '0) begin
                        next_rx_tmr[i] = {hd[22:0], 1'b0};
                        next_rx_sh[i] = {rxd, rx_sh[i][9:1]};
                        next_rx_n[i] = rx_n[i] + 4'h1;
                        if (rx_n[i] == nb) begin
                            v = next_rx_sh[i] >> (RX_SH_BITS - nb - 4'h1);
                            ch = v[7:0] & char_mask(lp_len[i]);
                            next_rx_hw[i] = {rx_hv[i] && next_rx_hv[i], !v[nb],
                                lp_par[i] && (^ch ^ v[ln] ^ lp_odd[i]), 1'b0, 3'(i), ch};
                            next_rx_hv[i] = 1'b1;
                            next_rx_st[i] = RX_IDLE;
                        end
                    end
                end
                default: next_rx_st[i] = RX_IDLE;
            endcase
            if (!lp_rxon[i] || !mse) begin
                next_rx_st[i] = RX_IDLE;
            end
            if (clr_now || !mse) begin
                next_rx_hv[i] = 1'b0;
            end
            if (clr_now) begin
                next_tx_full[i] = 1'b0;
            end
            next_tx_line[i] = !(brk[i] && !maint) && tx_sh[i][0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_tmr <= '{default: '0};
            rx_tmr <= '{default: '0};
            tx_sh <= '{default: 12'hfff};
            tx_half <= '{default: '0};
            rx_sh <= '{default: '0};
            rx_n <= '{default: '0};
            rx_hw <= '{default: '0};
            rx_st <= '{default: RX_IDLE};
            {tx_ph, tx_full, rx_hv} <= '0;
            tx_line <= 8'hff;
        end else begin
            tx_tmr <= next_tx_tmr;
            rx_tmr <= next_rx_tmr;
            tx_sh <= next_tx_sh;
            tx_half <= next_tx_half;
            rx_sh <= next_rx_sh;
            rx_n <= next_rx_n;
            rx_hw <= next_rx_hw;
            rx_st <= next_rx_st;
            {tx_ph, tx_full, rx_hv} <= {next_tx_ph, next_tx_full, next_rx_hv};
            tx_line <= next_tx_line;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence clr_issued;
        clr_now;
    endsequence
    dtr_keep_a: assert property (clr_issued |=> $stable(term_ready))
        else $error("terminal ready changed on soft clear");
    en_clear_a: assert property (clr_issued |=> line_en == 8'h0 && brk == 8'h0)
        else $error("line enable or break survived soft clear");
    msr_read_a: assert property (bus.rd && bus.addr == ADDR_MSR |=>
        rdata == (MODEM_PRESENT ? $past(modem) : 16'h0)) else $error("modem status wrong");
    brk_out_a: assert property ((brk & {8{!maint}}) != 8'h0 |=>
        (tx_line & $past(brk & {8{!maint}})) == 8'h0) else $error("break line not low");
    empty_read_a: assert property (rd_receive_buffer_word && !receive_done_flag |=> !rdata[RB_VALID])
        else $error("valid set on empty silo read");
    rx_irq_a: assert property (push_en && receiver_interrupt_enable && !silo_alarm_enable && !rd_receive_buffer_word |=> rx_intr)
        else $error("receiver irq missing");
    alarm_a: assert property (alarm_cnt == ALARM_COUNT - 5'h1 && push_en && !rd_receive_buffer_word
        && !clr_now |=> sa)
        else $error("alarm not set at count");
    one_irq_a: assert property (!(rx_intr && tx_intr))
        else $error("two irqs at once");
    transmit_character_byte_a: assert property (transmit_character_byte_wr |=> !transmitter_ready_flag ##0 tx_full[$past(tline)])
        else $error("ready not cleared by load");
endmodule : eslmc_top
